//--- sbt_params.svh
// constants of the serial bus pattern trigger: sizes, counts, reset values
// assumes nothing; included by the package and the design modules
`ifndef SBT_PARAMS_SVH
`define SBT_PARAMS_SVH

// widest bus word that can be compared
`define SBT_WORD_W 16
// narrow word length, also the i2c byte length
`define SBT_NARROW_W 8
// most elements one pattern may hold
`define SBT_ELEMS 16
// number of condition slots
`define SBT_SLOTS 4
// width of a pattern length field (0 .. 16 plus room to flag 17..31)
`define SBT_LEN_W 5
// i2c bits per byte slot, the last one being the acknowledge
`define SBT_I2C_BITS 9
// bit counter width in the link domain
`define SBT_CNT_W 4
// reset value of words and shift registers
`define SBT_WORD_RST 16'h0000

`endif

//--- sbt_pkg.sv
// types shared by the serial bus pattern trigger modules
// assumes sbt_params.svh sits in the include path
`include "sbt_params.svh"

package sbt_pkg;

	// one bus word as compared against a pattern element
	typedef logic [`SBT_WORD_W-1:0] sbt_word_t;

	// pattern length in elements
	typedef logic [`SBT_LEN_W-1:0] sbt_len_t;

	// which part of a condition slot is being searched
	typedef enum logic {
		SBT_ST_FIRST,
		SBT_ST_SECOND
	} sbt_stage_t;

endpackage

//--- sbt_slot.sv
// one if-then condition slot: two word sequences searched in turn
// assumes words arrive as single-cycle strobes on the main clock
`include "sbt_params.svh"
`timescale 1ns/1ps

module sbt_slot #(
	parameter int ELEMS = `SBT_ELEMS
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic enable,
	input wire logic restart,
	input wire sbt_pkg::sbt_len_t len_first,
	input wire sbt_pkg::sbt_len_t len_second,
	input wire sbt_pkg::sbt_word_t pat_first [ELEMS],
	input wire sbt_pkg::sbt_word_t pat_second [ELEMS],
	input wire logic wide,
	input wire logic word_valid,
	input wire sbt_pkg::sbt_word_t word,
	input wire logic word_first,
	output logic hit,
	output logic len_bad
);

	localparam int IDX_W = $clog2(ELEMS);

	// a depth of one leaves no index bits to count with
	if (ELEMS < 2 || ELEMS > `SBT_ELEMS) begin : g_bad_depth
		$error("slot depth must be 2 to 16");
	end

	sbt_pkg::sbt_stage_t stage; // part of the slot being searched
	sbt_pkg::sbt_stage_t next_stage;
	logic [IDX_W-1:0] idx; // next element expected
	logic [IDX_W-1:0] next_idx;
	logic next_hit;

	// a new frame throws away a half-seen sequence
	wire logic [IDX_W-1:0] eff_idx = word_first ? '0 : idx;
	wire sbt_pkg::sbt_len_t cur_len =
		(stage == sbt_pkg::SBT_ST_SECOND) ? len_second : len_first;
	wire sbt_pkg::sbt_word_t exp_word =
		(stage == sbt_pkg::SBT_ST_SECOND) ? pat_second[eff_idx]
		: pat_first[eff_idx];
	wire sbt_pkg::sbt_word_t exp_head =
		(stage == sbt_pkg::SBT_ST_SECOND) ? pat_second[0] : pat_first[0];
	// eight bit words compare the low byte only
	wire sbt_pkg::sbt_word_t mask = wide ? 16'hFFFF : 16'h00FF;
	// equal word value, however the user spelled it
	wire logic match = ((word ^ exp_word) & mask) == '0;
	wire logic match_head = ((word ^ exp_head) & mask) == '0;
	wire sbt_pkg::sbt_len_t seen = sbt_pkg::sbt_len_t'(eff_idx) + 5'h01;
	wire logic done = match && (seen == cur_len);
	// longer patterns are refused: the slot stays quiet
	wire logic bad = (len_first > ELEMS) || (len_second > ELEMS);
	wire logic live = enable && !bad && (len_first != '0);

	// next state of the sequence search
	always_comb begin
		next_stage = stage;
		next_idx = idx;
		next_hit = 1'b0;
		if (!live || restart) begin
			next_stage = sbt_pkg::SBT_ST_FIRST;
			next_idx = '0;
		end else if (word_valid) begin
			if (done) begin
				next_idx = '0;
				// second part must follow the first
				if (stage == sbt_pkg::SBT_ST_FIRST && len_second != '0) begin
					next_stage = sbt_pkg::SBT_ST_SECOND;
				end else begin
					next_stage = sbt_pkg::SBT_ST_FIRST;
					next_hit = 1'b1;
				end
			end else if (match) begin
				next_idx = IDX_W'(eff_idx + 1'b1);
			end else if (match_head) begin
				// mismatch may itself open a new run
				next_idx = IDX_W'(1);
			end else begin
				next_idx = '0;
			end
		end
	end

	// state registers
	always_ff @(posedge clock) begin
		if (srst) begin
			stage <= sbt_pkg::SBT_ST_FIRST;
			idx <= '0;
			hit <= 1'b0;
			len_bad <= 1'b0;
		end else begin
			stage <= next_stage;
			idx <= next_idx;
			hit <= next_hit;
			len_bad <= enable && bad;
		end
	end

endmodule

//--- sbt_trigger.sv
// protocol trigger of the analyzer: spi or i2c word capture and matching
// assumes probe pins are asynchronous, acq_clk is the probe sampling
// clock running free, and config inputs change only while disarmed
// srst must span at least one acq_clk rising edge; the link side
// leaves reset a few link cycles after srst falls, and words are
// ignored until then
`include "sbt_params.svh"
`timescale 1ns/1ps

module sbt_trigger #(
	parameter int SLOTS = `SBT_SLOTS,
	parameter int ELEMS = `SBT_ELEMS
) (
	// clocks and reset
	input wire logic clock,
	input wire logic srst,
	input wire logic acq_clk,
	// protocol setup, held while disarmed
	input wire logic mode_i2c,
	input wire logic cs_active_high,
	input wire logic sample_falling,
	input wire logic wide_words,
	input wire logic lsb_first,
	// condition slots
	input wire logic [SLOTS-1:0] slot_enable,
	input wire sbt_pkg::sbt_len_t len_first [SLOTS],
	input wire sbt_pkg::sbt_len_t len_second [SLOTS],
	input wire sbt_pkg::sbt_word_t pat_first [SLOTS][ELEMS],
	input wire sbt_pkg::sbt_word_t pat_second [SLOTS][ELEMS],
	// hold-off and arming, main clock
	input wire logic pretrig_en,
	input wire logic mem_prefilled,
	input wire logic arm,
	// probed pins, asynchronous to both clocks
	input wire logic spi_sclk,
	input wire logic spi_cs,
	input wire logic spi_data,
	input wire logic i2c_scl,
	input wire logic i2c_sda,
	// results, all registered
	output logic trig_pulse,
	output logic triggered,
	output logic word_strobe,
	output sbt_pkg::sbt_word_t last_word,
	output logic [SLOTS-1:0] cfg_error
);

	// refuse sizes the matcher cannot serve
	if (SLOTS < 1 || SLOTS > `SBT_SLOTS) begin : g_bad_slots
		$error("slot count must be 1 to 4");
	end
	if (ELEMS < 2 || ELEMS > `SBT_ELEMS) begin : g_bad_elems
		$error("pattern depth must be 2 to 16");
	end

	// ---------------- link domain (acq_clk) ----------------

	logic [1:0] rst_l; // main reset carried into the link domain
	// link_rst also crosses back to tell the main side it is done
	wire logic link_rst = rst_l[1];

	// reset crossing: a level, two flops
	always_ff @(posedge acq_clk) begin
		rst_l <= {rst_l[0], srst};
	end

	// configuration crossed as static levels
	logic [4:0] cfg_m; // first flop, read only by cfg_s
	logic [4:0] cfg_s;
	wire logic l_i2c = cfg_s[4];
	wire logic l_cs_high = cfg_s[3];
	wire logic l_falling = cfg_s[2];
	wire logic l_wide = cfg_s[1] & ~cfg_s[4]; // i2c is bytes only
	wire logic l_lsb = cfg_s[0] & ~cfg_s[4];

	// settings only change while disarmed, so a level pair is enough
	always_ff @(posedge acq_clk) begin
		cfg_m <= {mode_i2c, cs_active_high, sample_falling, wide_words,
			lsb_first};
		cfg_s <= cfg_m;
	end

	// probe pins: two flops, then one more to see edges
	// edges are judged between two synchronised samples, never pin_m
	logic [4:0] pin_m; // first flop, read only by pin_s
	logic [4:0] pin_s; // synchronised pins
	logic [4:0] pin_p; // previous synchronised pins

	// the three spi lines and the two i2c lines
	always_ff @(posedge acq_clk) begin
		pin_m <= {spi_sclk, spi_cs, spi_data, i2c_scl, i2c_sda};
		pin_s <= pin_m;
		pin_p <= pin_s;
	end

	// synchronised pins by name, with the two clocks and sda also one cycle back
	wire logic sclk_now = pin_s[4];
	wire logic sclk_was = pin_p[4];
	wire logic cs_now = pin_s[3];
	wire logic sdat_now = pin_s[2];
	wire logic scl_now = pin_s[1];
	wire logic scl_was = pin_p[1];
	wire logic sda_now = pin_s[0];
	wire logic sda_was = pin_p[0];

	// select active at the configured level
	wire logic cs_act = (cs_now == l_cs_high);
	// sample on the chosen serial clock edge
	wire logic spi_edge = l_falling ? (sclk_was & ~sclk_now)
		: (~sclk_was & sclk_now);
	// i2c start and stop: data moves while the clock is high
	wire logic i2c_start = scl_now & scl_was & sda_was & ~sda_now;
	wire logic i2c_stop = scl_now & scl_was & ~sda_was & sda_now;
	wire logic i2c_rise = ~scl_was & scl_now;

	// assembly state and the word offered across to the main side
	sbt_pkg::sbt_word_t shreg; // bits gathered so far
	sbt_pkg::sbt_word_t next_shreg;
	logic [`SBT_CNT_W-1:0] bit_cnt; // bits taken in this word
	logic [`SBT_CNT_W-1:0] next_bit_cnt;
	logic fresh; // next word is the first of its frame
	logic next_fresh;
	logic in_frame; // i2c between start and stop
	logic next_in_frame;
	sbt_pkg::sbt_word_t link_word; // word on offer to the main side
	sbt_pkg::sbt_word_t next_link_word;
	logic link_first; // offered word opens a frame
	logic next_link_first;
	logic link_tgl; // flips once per offered word
	logic next_link_tgl;

	// count of the last bit of a word, counted from zero
	wire logic [`SBT_CNT_W-1:0] last_bit = l_wide ? 4'hF : 4'h7;
	// the new bit enters at the top or the bottom
	wire sbt_pkg::sbt_word_t spi_shift = l_lsb ? {sdat_now, shreg[15:1]}
		: {shreg[14:0], sdat_now};
	// lsb-first narrow words end up in the top byte
	wire sbt_pkg::sbt_word_t spi_word = (l_lsb && !l_wide)
		? {8'h00, spi_shift[15:8]}
		: (l_wide ? spi_shift : {8'h00, spi_shift[7:0]});
	// i2c always shifts msb first
	wire sbt_pkg::sbt_word_t i2c_shift = {shreg[14:0], sda_now};

	// word assembly for both protocols
	always_comb begin
		next_shreg = shreg;
		next_bit_cnt = bit_cnt;
		next_fresh = fresh;
		next_in_frame = in_frame;
		next_link_word = link_word;
		next_link_first = link_first;
		next_link_tgl = link_tgl;
		// spi first; i2c below keys on start, stop and clock rises
		if (!l_i2c) begin
			next_in_frame = 1'b0;
			if (!cs_act) begin
				// idle select: drop partial word, next one opens a frame
				next_bit_cnt = '0;
				next_fresh = 1'b1;
			end else if (spi_edge) begin
				next_shreg = spi_shift;
				next_bit_cnt = bit_cnt + 1'b1;
				if (bit_cnt == last_bit) begin
					next_bit_cnt = '0;
					next_link_word = spi_word;
					next_link_first = fresh;
					next_link_tgl = ~link_tgl;
					next_fresh = 1'b0;
				end
			end
		end else if (i2c_start) begin
			// a repeated start also opens a new frame
			next_in_frame = 1'b1;
			next_bit_cnt = '0;
			next_fresh = 1'b1;
		end else if (i2c_stop) begin
			next_in_frame = 1'b0;
			next_bit_cnt = '0;
		end else if (i2c_rise && in_frame) begin
			if (bit_cnt == `SBT_CNT_W'(`SBT_I2C_BITS - 1)) begin
				// acknowledge clock: seen, never compared
				next_bit_cnt = '0;
			end else begin
				next_shreg = i2c_shift;
				next_bit_cnt = bit_cnt + 1'b1;
				if (bit_cnt == `SBT_CNT_W'(`SBT_NARROW_W - 1)) begin
					next_link_word = {8'h00, i2c_shift[7:0]};
					next_link_first = fresh;
					next_link_tgl = ~link_tgl;
					next_fresh = 1'b0;
				end
			end
		end
	end

	// link domain registers
	always_ff @(posedge acq_clk) begin
		if (link_rst) begin
			shreg <= `SBT_WORD_RST;
			bit_cnt <= '0;
			fresh <= 1'b1;
			in_frame <= 1'b0;
			link_word <= `SBT_WORD_RST;
			link_first <= 1'b0;
			link_tgl <= 1'b0;
		end else begin
			shreg <= next_shreg;
			bit_cnt <= next_bit_cnt;
			fresh <= next_fresh;
			in_frame <= next_in_frame;
			link_word <= next_link_word;
			link_first <= next_link_first;
			link_tgl <= next_link_tgl;
		end
	end

	// ---------------- main domain (clock) ----------------

	// word handshake: the toggle crosses, the word is held behind it;
	// at least eight link cycles pass between words, so the data is
	// long stable when the main side reads it
	logic tgl_m; // first flop, read only by tgl_s
	logic tgl_s;
	logic tgl_seen;

	// toggle synchroniser with its own edge memory
	always_ff @(posedge clock) begin
		if (srst) begin
			tgl_m <= 1'b0;
			tgl_s <= 1'b0;
			tgl_seen <= 1'b0;
		end else begin
			tgl_m <= link_tgl;
			tgl_s <= tgl_m;
			tgl_seen <= tgl_s;
		end
	end

	// the link side leaves reset a few link cycles after srst falls;
	// until its reset level has crossed back here and dropped, its
	// toggle is not yet defined and no word is accepted
	logic back_m; // first flop, read only by back_s
	logic back_s; // link reset as seen on the main clock
	logic back_was; // back_s one cycle ago
	logic link_up; // link side out of reset and running

	// link reset carried back over two flops, one more for its fall
	always_ff @(posedge clock) begin
		if (srst) begin
			back_m <= 1'b0;
			back_s <= 1'b0;
			back_was <= 1'b0;
			link_up <= 1'b0;
		end else begin
			back_m <= link_rst;
			back_s <= back_m;
			back_was <= back_s;
			// an undefined level before the first link edge sets nothing
			if (back_was && !back_s) begin
				link_up <= 1'b1;
			end
		end
	end

	// a word is new when the crossed toggle moves
	wire logic word_valid = link_up & (tgl_s ^ tgl_seen);
	// i2c bytes are narrow whatever wide_words says
	wire logic wide_eff = wide_words & ~mode_i2c;

	// per-slot results on the main clock
	logic [SLOTS-1:0] slot_hit; // one pulse per finished slot
	logic [SLOTS-1:0] slot_bad; // slot refused for length

	// one matcher per condition slot
	// arm restarts every slot, so no arming inherits half a match
	for (genvar s = 0; s < SLOTS; s++) begin : g_slot
		sbt_slot #(
			.ELEMS(ELEMS)
		) u_slot (
			.clock(clock),
			.srst(srst),
			.enable(slot_enable[s]),
			.restart(arm),
			.len_first(len_first[s]),
			.len_second(len_second[s]),
			.pat_first(pat_first[s]),
			.pat_second(pat_second[s]),
			.wide(wide_eff),
			.word_valid(word_valid),
			.word(link_word),
			.word_first(link_first),
			.hit(slot_hit[s]),
			.len_bad(slot_bad[s])
		);
	end

	// any one enabled slot is enough
	wire logic any_hit = |slot_hit;
	// pre-trigger: matches are thrown away until memory is prefilled
	wire logic hit_ok = any_hit & (~pretrig_en | mem_prefilled);
	// fire once per arming; a new arm wins over a late hit
	// a hit landing with arm belongs to the old arming and is dropped
	wire logic fire = hit_ok & ~triggered & ~arm;

	// trigger and status outputs; trig_pulse marks the trigger point,
	// one cycle after the strobe of the word that completed a slot
	// last_word holds between strobes so it can be read late
	always_ff @(posedge clock) begin
		if (srst) begin
			trig_pulse <= 1'b0;
			triggered <= 1'b0;
			word_strobe <= 1'b0;
			last_word <= `SBT_WORD_RST;
			cfg_error <= '0;
		end else begin
			trig_pulse <= fire;
			triggered <= arm ? 1'b0 : (triggered | fire);
			word_strobe <= word_valid;
			if (word_valid) begin
				last_word <= link_word;
			end
			cfg_error <= slot_bad;
		end
	end

endmodule

//--- sbt_trigger_checker.sv
// port checks of the trigger: pulses, sticky level, word form
// assumes binding onto sbt_trigger; all checks on the main clock
`timescale 1ns/1ps
module sbt_trigger_checker #(
	parameter int SLOTS = 4
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic arm,
	input wire logic mode_i2c,
	input wire logic wide_words,
	input wire logic [SLOTS-1:0] slot_enable,
	input wire logic pretrig_en,
	input wire logic mem_prefilled,
	input wire logic trig_pulse,
	input wire logic triggered,
	input wire logic word_strobe,
	input wire sbt_pkg::sbt_word_t last_word,
	input wire logic [SLOTS-1:0] cfg_error
);
	// quiet while reset is held
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	a_trig_after_word: assert property (trig_pulse |-> $past(word_strobe))
		else $error("trigger not one cycle after a word");
	a_pulse_single: assert property (trig_pulse |=> !trig_pulse)
		else $error("trigger pulse too long");
	a_pulse_sets_level: assert property (trig_pulse |-> triggered)
		else $error("pulse without level");
	a_level_sticky: assert property (triggered && !arm |=> triggered)
		else $error("trigger level dropped");
	a_one_per_arm: assert property (triggered && !arm |=> !trig_pulse)
		else $error("second trigger in one arm");
	a_arm_clears: assert property (arm |=> !triggered)
		else $error("arm left trigger set");
	// three cycles cover the hit pipeline behind a pulse
	a_pretrig_hold: assert property (
		(pretrig_en && !mem_prefilled)[*3] |-> !trig_pulse)
		else $error("trigger before memory filled");
	a_narrow_word: assert property (word_strobe && (mode_i2c || !wide_words)
		|-> last_word[15:8] == 8'h00)
		else $error("narrow word has high byte");
	a_word_spacing: assert property (word_strobe |=> !word_strobe[*8])
		else $error("words too close");
	a_word_held: assert property (!word_strobe |-> $stable(last_word))
		else $error("word changed without strobe");
	a_bad_slot_quiet: assert property (
		trig_pulse |-> |(slot_enable & ~cfg_error))
		else $error("trigger with no usable slot");
endmodule

bind sbt_trigger sbt_trigger_checker #(.SLOTS(SLOTS)) sbt_trigger_checker_inst (
	.clock(clock), .srst(srst), .arm(arm), .mode_i2c(mode_i2c),
	.wide_words(wide_words), .slot_enable(slot_enable),
	.pretrig_en(pretrig_en), .mem_prefilled(mem_prefilled),
	.trig_pulse(trig_pulse), .triggered(triggered),
	.word_strobe(word_strobe), .last_word(last_word), .cfg_error(cfg_error));

//--- sbt_bus_model.sv
// target bus model: spi and i2c traffic on the probed pins
// assumes acq_clk free running; pins change just after its rising edge
`timescale 1ns/1ps
module sbt_bus_model (
	input wire logic acq_clk,
	output logic spi_sclk,
	output logic spi_cs,
	output logic spi_data,
	output logic i2c_scl,
	output logic i2c_sda
);
	// idle: spi clock low and still, i2c lines pulled high
	initial begin
		spi_sclk = 1'b0;
		spi_cs = 1'b1;
		spi_data = 1'b0;
		i2c_scl = 1'b1;
		i2c_sda = 1'b1;
	end
	// two sampling periods a phase, so the synchroniser sees each one
	task automatic gap();
		repeat (2) @(posedge acq_clk);
	endtask
	// select on or off for the given active level
	task automatic cs_set(input logic on, input logic hi);
		gap();
		spi_cs <= on ? hi : !hi;
		// released data line must not keep its last value
		if (!on) spi_data <= !spi_data;
		gap();
	endtask
	// data settles while clock low and holds over both edges
	task automatic spi_word(input logic [15:0] w, input int n, input logic l);
		for (int i = 0; i < n; i++) begin
			gap();
			spi_data <= l ? w[i] : w[n-1-i];
			gap();
			spi_sclk <= 1'b1;
			gap();
			spi_sclk <= 1'b0;
		end
	endtask
	// start: data falls while clock high
	task automatic i2c_start();
		gap();
		i2c_sda <= 1'b0;
		gap();
		i2c_scl <= 1'b0;
	endtask
	// eight bits msb first, then an acknowledge held low
	task automatic i2c_byte(input logic [7:0] b);
		for (int i = 0; i < 9; i++) begin
			gap();
			i2c_sda <= (i < 8) ? b[7-i] : 1'b0;
			gap();
			i2c_scl <= 1'b1;
			gap();
			i2c_scl <= 1'b0;
		end
	endtask
	// stop: data rises while clock high, lines then float high
	task automatic i2c_stop();
		gap();
		i2c_sda <= 1'b0;
		gap();
		i2c_scl <= 1'b1;
		gap();
		i2c_sda <= 1'b1;
		gap();
	endtask
endmodule

//--- sbt_trigger_tb.sv
// bench of the trigger: spi case table, then hand cases
// assumes sbt_bus_model drives the pins
`timescale 1ns/1ps
module sbt_trigger_tb;
	localparam int S = 4;
	localparam int E = 16;
	logic clock = 1'b0, acq_clk = 1'b0, srst = 1'b1, arm = 1'b0;
	logic mode_i2c = 1'b0, cs_active_high = 1'b0, sample_falling = 1'b0;
	logic wide_words = 1'b0, lsb_first = 1'b0;
	logic pretrig_en = 1'b0, mem_prefilled = 1'b0;
	logic [S-1:0] slot_enable = '0;
	sbt_pkg::sbt_len_t len_first [S], len_second [S];
	sbt_pkg::sbt_word_t pat_first [S][E], pat_second [S][E];
	logic spi_sclk, spi_cs, spi_data, i2c_scl, i2c_sda;
	logic trig_pulse, triggered, word_strobe;
	sbt_pkg::sbt_word_t last_word;
	logic [S-1:0] cfg_error;
	logic [15:0] q [$];
	int n_fail = 0, n_tests = 0, cyc = 0, n_words = 0, n0;
	// wide, lsb first, select high, falling, word sent, pattern, trigger
	typedef struct {logic w, l, h, f; logic [15:0] d, p; logic t;} sbt_row_t;
	sbt_row_t rows [5] = '{'{0, 0, 0, 0, 16'h007A, 16'h007A, 1},
		'{1, 1, 1, 1, 16'hA53C, 16'hA53C, 1},
		'{0, 1, 1, 0, 16'h00B2, 16'hC3B2, 1},
		'{1, 0, 0, 1, 16'h1234, 16'h1234, 1},
		'{0, 0, 1, 1, 16'h0041, 16'h0042, 0}};
	// link clock phase kept off the main clock's edges
	always #4 clock = ~clock;
	always begin
		#37 acq_clk = ~acq_clk;
		#3;
	end
	sbt_trigger sbt_trigger_inst (.clock(clock), .srst(srst),
		.acq_clk(acq_clk), .mode_i2c(mode_i2c), .cs_active_high(cs_active_high),
		.sample_falling(sample_falling), .wide_words(wide_words),
		.lsb_first(lsb_first), .slot_enable(slot_enable), .len_first(len_first),
		.len_second(len_second), .pat_first(pat_first),
		.pat_second(pat_second), .pretrig_en(pretrig_en),
		.mem_prefilled(mem_prefilled), .arm(arm), .spi_sclk(spi_sclk),
		.spi_cs(spi_cs), .spi_data(spi_data), .i2c_scl(i2c_scl),
		.i2c_sda(i2c_sda), .trig_pulse(trig_pulse), .triggered(triggered),
		.word_strobe(word_strobe), .last_word(last_word),
		.cfg_error(cfg_error));
	sbt_bus_model sbt_bus_model_inst (.acq_clk(acq_clk), .spi_sclk(spi_sclk),
		.spi_cs(spi_cs), .spi_data(spi_data), .i2c_scl(i2c_scl),
		.i2c_sda(i2c_sda));
	// word count and cycle ceiling; the sequence needs about 20000
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (word_strobe === 1'b1) n_words <= n_words + 1;
		if (cyc == 60000) begin
			n_fail++;
			stop_test();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("compares %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// levels set and slots cleared while disarmed
	task automatic setup(input logic w, l, h, f, i2c);
		@(negedge clock);
		{wide_words, lsb_first, cs_active_high} = {w, l, h};
		{sample_falling, mode_i2c, slot_enable} = {f, i2c, 4'h0};
		for (int s = 0; s < S; s++) {len_first[s], len_second[s]} = '0;
		sbt_bus_model_inst.cs_set(1'b0, h);
		@(negedge clock);
	endtask
	task automatic rearm();
		@(negedge clock);
		arm = 1'b1;
		@(negedge clock);
		arm = 1'b0;
	endtask
	// one select frame carrying the queued words
	task automatic spi_frame(input logic [15:0] f[$]);
		sbt_bus_model_inst.cs_set(1'b1, cs_active_high);
		foreach (f[k]) sbt_bus_model_inst.spi_word(f[k],
			wide_words ? 16 : 8, lsb_first);
		sbt_bus_model_inst.cs_set(1'b0, cs_active_high);
	endtask
	// slot 0 on, one element
	task automatic one(input logic [15:0] p);
		{slot_enable[0], len_first[0], pat_first[0][0]} = {1'b1, 5'h01, p};
	endtask
	initial begin
		foreach (pat_first[s, e]) {pat_first[s][e], pat_second[s][e]} = '0;
		for (int s = 0; s < S; s++) {len_first[s], len_second[s]} = '0;
		// ten cycles span one link edge; the link side catches up later
		repeat (10) @(negedge clock);
		srst = 1'b0;
		@(negedge clock);
		check({trig_pulse, triggered, word_strobe, cfg_error}, 16'h0000);
		check(last_word, 16'h0000);
		$display("power-up reset done");
		repeat (3) @(posedge acq_clk);
		foreach (rows[i]) begin
			setup(rows[i].w, rows[i].l, rows[i].h, rows[i].f, 1'b0);
			one(rows[i].p);
			rearm();
			spi_frame({rows[i].d});
			check(last_word, rows[i].d);
			check(16'(triggered), 16'(rows[i].t));
			$display("row %0d done", i);
		end
		// two-stage slot; restart on mismatch and on a new frame
		setup(0, 0, 0, 0, 0);
		slot_enable = 4'hC;
		{len_first[2], len_second[2], len_first[3]} = {5'h02, 5'h01, 5'h01};
		{pat_first[2][0], pat_first[2][1]} = {16'h0041, 16'h0063};
		{pat_second[2][0], pat_first[3][0]} = {16'h0075, 16'h0099};
		rearm();
		spi_frame({16'h0041});
		spi_frame({16'h0063, 16'h0075});
		check(16'(triggered), 16'h0000);
		spi_frame({16'h0041, 16'h0075, 16'h0041, 16'h0063});
		check(16'(triggered), 16'h0000);
		spi_frame({16'h0075});
		check(16'(triggered), 16'h0001);
		rearm();
		check(16'(triggered), 16'h0000);
		$display("two-stage done");
		// sixteen elements accepted, seventeen flagged
		setup(0, 0, 0, 0, 0);
		slot_enable = 4'h3;
		{len_first[0], len_first[1]} = {5'h10, 5'h11};
		q = {};
		for (int e = 0; e < E; e++) begin
			pat_first[0][e] = 16'h0010 + 16'(e);
			q.push_back(16'h0010 + 16'(e));
		end
		rearm();
		repeat (3) @(negedge clock);
		check(16'(cfg_error), 16'h0002);
		spi_frame(q);
		check(16'(triggered), 16'h0001);
		$display("length limit done");
		// hold-off until memory is filled
		setup(0, 0, 0, 0, 0);
		one(16'h007A);
		{pretrig_en, mem_prefilled} = 2'b10;
		rearm();
		spi_frame({16'h007A});
		check(16'(triggered), 16'h0000);
		@(negedge clock);
		mem_prefilled = 1'b1;
		spi_frame({16'h007A});
		check(16'(triggered), 16'h0001);
		@(negedge clock);
		pretrig_en = 1'b0;
		$display("hold-off done");
		// a partial word dropped when select goes idle
		setup(0, 0, 0, 0, 0);
		one(16'h007A);
		rearm();
		n0 = n_words;
		sbt_bus_model_inst.cs_set(1'b1, 1'b0);
		sbt_bus_model_inst.spi_word(16'h0003, 5, 1'b0);
		sbt_bus_model_inst.cs_set(1'b0, 1'b0);
		spi_frame({16'h007A});
		check(16'(n_words - n0), 16'h0001);
		check(16'(triggered), 16'h0001);
		$display("partial word done");
		// i2c bytes, acknowledge left out
		setup(0, 0, 0, 0, 1);
		{slot_enable[0], len_first[0]} = {1'b1, 5'h02};
		{pat_first[0][0], pat_first[0][1]} = {16'h0069, 16'h003C};
		rearm();
		sbt_bus_model_inst.i2c_start();
		sbt_bus_model_inst.i2c_byte(8'h69);
		sbt_bus_model_inst.i2c_byte(8'h3C);
		sbt_bus_model_inst.i2c_stop();
		check(last_word, 16'h003C);
		check(16'(triggered), 16'h0001);
		$display("i2c done");
		// reset in mid-run: outputs clear, words flow again after it
		@(negedge clock);
		srst = 1'b1;
		repeat (10) @(negedge clock);
		srst = 1'b0;
		@(negedge clock);
		check({trig_pulse, triggered, word_strobe, cfg_error}, 16'h0000);
		check(last_word, 16'h0000);
		repeat (3) @(posedge acq_clk);
		setup(0, 0, 0, 0, 0);
		one(16'h007A);
		rearm();
		spi_frame({16'h007A});
		check(last_word, 16'h007A);
		check(16'(triggered), 16'h0001);
		$display("mid-run reset done");
		stop_test();
	end
endmodule
